// >>> core/odg_core.sv
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module odg_core #(
  parameter int unsigned CSF_CYCLES = odg_pkg::CSF_CYCLES,
  parameter int unsigned SLOT_W     = 7
) (
  input  wire logic              SYS_CLK_I,
  input  wire logic              RSTN_I,
  input  wire logic [7:0]        AVS_ADDRESS_I,
  input  wire logic              AVS_READ_I,
  input  wire logic              AVS_WRITE_I,
  input  wire logic [31:0]       AVS_WRITEDATA_I,
  input  wire logic [3:0]        AVS_BYTEENABLE_I,
  output logic [31:0]            AVS_READDATA_O,
  output logic                   AVS_WAITREQUEST_O,
  input  wire logic              SIG_FAIL_I,
  input  wire logic              CLIENT_FAIL_I,
  input  wire logic [SLOT_W-1:0] SLOT_I,
  output odg_pkg::odg_src_e      SLOT_SRC_O,
  output logic [7:0]             PM_BYTE3_O,
  output logic [31:0]            APS_O,
  output logic [7:0]             PSI0_O,
  output logic                   REPL_10B_O,
  output logic [9:0]             REPL_CODE_O,
  output logic                   GFP_IDLE_O,
  output logic                   GFP_CMF_O,
  output logic                   CMF_REQ_O,
  output odg_pkg::odg_hdr_s      GFP_HDR_O,
  input  wire logic              RX_HDR_VALID_I,
  input  wire logic              RX_HDR_OK_I,
  output logic                   RX_SYNC_O
);

  // delineation states
  typedef enum logic [1:0] {ST_HUNT, ST_PRESYNC, ST_SYNC} odg_sync_e;

  odg_pkg::odg_pm_s  pm;            // path monitor config
  odg_pkg::odg_aps_s aps;           // protection byte one config
  logic [23:0]       aps_ext;       // protection bytes two to four
  odg_pkg::odg_psi_s psi;           // payload type config
  logic [SLOT_W:0]   trib;          // fill mode over measured slot
  odg_pkg::odg_gfp_s gfp;           // gfp config
  logic [3:0]        sync_thr;      // core header sync threshold
  logic              ack;           // second cycle of an access
  logic [1:0]        sf_sync;       // signal fail synchroniser
  logic [1:0]        cf_sync;       // client fail synchroniser
  logic [31:0]       csf_cnt;       // cycles to next cmf
  logic [3:0]        good_cnt;      // consecutive good headers
  odg_sync_e         sync_st;       // delineation state
  logic              sig_fail;      // synchronised signal fail
  logic              client_fail;   // synchronised client fail
  logic              csf_active;    // cmf replacement running
  logic              do_wr;         // write takes effect
  logic [31:0]       rd_word;       // read mux
  logic [31:0]       wr_word;       // addressed register with write lanes merged

  // merge write data into a word under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // map a status mode to its defined code
  function automatic logic [2:0] stat_code(input logic [1:0] mode);
    case (mode)
      2'd1:    return odg_pkg::STAT_LCK;
      2'd2:    return odg_pkg::STAT_OCI;
      2'd3:    return odg_pkg::STAT_AIS;
      default: return odg_pkg::STAT_NORMAL;
    endcase
  endfunction

  // true for a defined protection request
  function automatic logic aps_defined(input logic [3:0] code);
    case (code)
      odg_pkg::APS_NR, odg_pkg::APS_DNR, odg_pkg::APS_RR,
      odg_pkg::APS_EXER, odg_pkg::APS_WT, odg_pkg::APS_MS,
      odg_pkg::APS_SD, odg_pkg::APS_SF, odg_pkg::APS_FS,
      odg_pkg::APS_LO: return 1'b1;
      default:         return 1'b0;
    endcase
  endfunction

  // map a payload selection to its code
  function automatic logic [7:0] psi_code(input logic [2:0] sel);
    case (sel)
      3'd1:    return odg_pkg::PT_NULL;
      3'd2:    return odg_pkg::PT_PRBS;
      3'd3:    return odg_pkg::PT_PROP;
      3'd4:    return odg_pkg::PT_NA;
      default: return odg_pkg::PT_GFP;
    endcase
  endfunction

  // one wait cycle, then the access completes
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack;
  assign do_wr             = AVS_WRITE_I & ack;
  // the read mux already holds the addressed register, so lanes merge over it
  assign wr_word           = be_merge(rd_word, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  assign sig_fail          = sf_sync[1];
  assign client_fail       = cf_sync[1];
  assign csf_active        = client_fail & gfp.transp & gfp.csf_mode;

  // access phase tracker
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      ack <= 1'b0;
    end else begin
      ack <= (AVS_READ_I | AVS_WRITE_I) & ~ack;
    end
  end

  // read decode, unmapped reads return zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (AVS_ADDRESS_I)
      odg_pkg::OFF_PM:   rd_word = 32'(pm);
      odg_pkg::OFF_APS:  rd_word = 32'(aps);
      odg_pkg::OFF_APSX: rd_word = 32'(aps_ext);
      odg_pkg::OFF_PSI:  rd_word = 32'(psi);
      odg_pkg::OFF_TRIB: rd_word = 32'(trib);
      odg_pkg::OFF_GFP:  rd_word = 32'(gfp);
      odg_pkg::OFF_SYNC: rd_word = 32'(sync_thr);
      odg_pkg::OFF_STAT: rd_word = {28'h000_0000, csf_active, RX_SYNC_O, client_fail, sig_fail};
      default:           rd_word = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      AVS_READDATA_O <= 32'h0000_0000;
    end else if (AVS_READ_I && !ack) begin
      AVS_READDATA_O <= rd_word;
    end
  end

  // configuration registers, unmapped writes ignored
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      pm       <= odg_pkg::odg_pm_s'(odg_pkg::RST_PM[6:0]);
      aps      <= odg_pkg::odg_aps_s'(odg_pkg::RST_APS[9:0]);
      aps_ext  <= odg_pkg::RST_APS[23:0];
      psi      <= odg_pkg::odg_psi_s'(odg_pkg::RST_PSI[11:0]);
      trib     <= odg_pkg::RST_TRIB[SLOT_W:0];
      gfp      <= odg_pkg::odg_gfp_s'(odg_pkg::RST_GFP[17:0]);
      sync_thr <= odg_pkg::RST_SYNC[3:0];
    end else if (do_wr) begin
      case (AVS_ADDRESS_I)
        odg_pkg::OFF_PM:   pm       <= odg_pkg::odg_pm_s'(wr_word[6:0]);
        odg_pkg::OFF_APS:  aps      <= odg_pkg::odg_aps_s'(wr_word[9:0]);
        odg_pkg::OFF_APSX: aps_ext  <= wr_word[23:0];
        odg_pkg::OFF_PSI:  psi      <= odg_pkg::odg_psi_s'(wr_word[11:0]);
        odg_pkg::OFF_TRIB: trib     <= wr_word[SLOT_W:0];
        odg_pkg::OFF_GFP:  gfp      <= odg_pkg::odg_gfp_s'(wr_word[17:0]);
        odg_pkg::OFF_SYNC: sync_thr <= wr_word[3:0];
        default: ;
      endcase
    end
  end

  // pin synchronisers
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      sf_sync <= 2'b00;
      cf_sync <= 2'b00;
    end else begin
      sf_sync <= {sf_sync[0], SIG_FAIL_I};
      cf_sync <= {cf_sync[0], CLIENT_FAIL_I};
    end
  end

  // path monitor third byte: bei zero, bdi, stat
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      PM_BYTE3_O <= {5'h00, odg_pkg::STAT_NORMAL};
    end else begin
      PM_BYTE3_O[7:4] <= 4'h0;
      PM_BYTE3_O[3]   <= sig_fail | pm.bdi_force;
      // raw codes may be reserved, mode codes never are
      PM_BYTE3_O[2:0] <= pm.raw_en ? pm.raw : stat_code(pm.mode);
    end
  end

  // protection bytes; sf request when auto and failing and raw enable is off
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      APS_O <= 32'h0000_0000;
    end else begin
      APS_O[27:24] <= aps.prot;
      APS_O[23:0]  <= aps_ext;
      if (aps.raw_en) begin
        APS_O[31:28] <= aps.req;
      end else if (aps.auto_sf && sig_fail) begin
        APS_O[31:28] <= odg_pkg::APS_SF;
      end else if (aps_defined(aps.req)) begin
        APS_O[31:28] <= aps.req;
      end else begin
        APS_O[31:28] <= odg_pkg::APS_NR;
      end
    end
  end

  // payload type byte zero
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      PSI0_O <= odg_pkg::PT_GFP;
    end else begin
      PSI0_O <= psi.raw_en ? psi.raw : psi_code(psi.sel);
    end
  end

  // source of the slot now being built
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      SLOT_SRC_O <= odg_pkg::SRC_MEAS;
    end else if (SLOT_I == trib[SLOT_W-1:0]) begin
      SLOT_SRC_O <= odg_pkg::SRC_MEAS;
    end else if (trib[SLOT_W]) begin
      SLOT_SRC_O <= odg_pkg::SRC_COPY;
    end else begin
      SLOT_SRC_O <= odg_pkg::SRC_PRBS;
    end
  end

  // client fail replacement in transparent mode
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      REPL_10B_O  <= 1'b0;
      REPL_CODE_O <= 10'h000;
      GFP_IDLE_O  <= 1'b0;
    end else begin
      REPL_10B_O  <= client_fail & gfp.transp & ~gfp.csf_mode;
      REPL_CODE_O <= odg_pkg::ERR_10B;
      GFP_IDLE_O  <= csf_active;
    end
  end

  // cmf interval: first at once, then every interval
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      csf_cnt   <= 32'h0000_0000;
      CMF_REQ_O <= 1'b0;
    end else if (!csf_active) begin
      csf_cnt   <= 32'h0000_0000;
      CMF_REQ_O <= 1'b0;
    end else if (csf_cnt == 32'h0000_0000) begin
      csf_cnt   <= 32'(CSF_CYCLES - 1);
      CMF_REQ_O <= 1'b1;
    end else begin
      csf_cnt   <= csf_cnt - 32'h0000_0001;
      CMF_REQ_O <= 1'b0;
    end
  end

  // frame-mapped header, overridden by cmf replacement
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      GFP_HDR_O <= '0;
      GFP_CMF_O <= 1'b0;
    end else if (csf_active) begin
      GFP_HDR_O <= {odg_pkg::PTI_CMF, 1'b0, 4'h0, odg_pkg::UPI_LOS};
      GFP_CMF_O <= 1'b1;
    end else begin
      GFP_HDR_O.pti <= gfp.hdr.pti;
      GFP_HDR_O.pfi <= gfp.hdr.pfi;
      GFP_HDR_O.exi <= gfp.hdr.exi;
      GFP_HDR_O.upi <= gfp.hdr.upi;
      GFP_CMF_O     <= (gfp.hdr.pti == odg_pkg::PTI_CMF);
    end
  end

  // receive delineation, a bad header drops to hunt
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      sync_st  <= ST_HUNT;
      good_cnt <= 4'h0;
    end else if (RX_HDR_VALID_I) begin
      case (sync_st)
        ST_HUNT, ST_PRESYNC: begin
          if (!RX_HDR_OK_I) begin
            sync_st  <= ST_HUNT;
            good_cnt <= 4'h0;
          end else if (good_cnt + 4'h1 >= sync_thr) begin
            sync_st  <= ST_SYNC;
            good_cnt <= 4'h0;
          end else begin
            sync_st  <= ST_PRESYNC;
            good_cnt <= good_cnt + 4'h1;
          end
        end
        ST_SYNC: begin
          if (!RX_HDR_OK_I) begin
            sync_st <= ST_HUNT;
          end
        end
        default: begin
          sync_st <= ST_HUNT;
        end
      endcase
    end
  end

  assign RX_SYNC_O = (sync_st == ST_SYNC);

endmodule
`default_nettype wire

// >>> shared/odg_pkg.sv
package odg_pkg;
  // register byte offsets on the avalon slave
  localparam logic [7:0] OFF_PM   = 8'h00;
  localparam logic [7:0] OFF_APS  = 8'h04;
  localparam logic [7:0] OFF_APSX = 8'h08;
  localparam logic [7:0] OFF_PSI  = 8'h0C;
  localparam logic [7:0] OFF_TRIB = 8'h10;
  localparam logic [7:0] OFF_GFP  = 8'h14;
  localparam logic [7:0] OFF_SYNC = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  // path status codes
  localparam logic [2:0] STAT_NORMAL = 3'h1;
  localparam logic [2:0] STAT_LCK    = 3'h5;
  localparam logic [2:0] STAT_OCI    = 3'h6;
  localparam logic [2:0] STAT_AIS    = 3'h7;
  // protection request codes
  localparam logic [3:0] APS_NR = 4'h0, APS_DNR = 4'h1, APS_RR = 4'h2, APS_EXER = 4'h4;
  localparam logic [3:0] APS_WT = 4'h6, APS_MS = 4'h8, APS_SD = 4'hA, APS_SF = 4'hC;
  localparam logic [3:0] APS_FS = 4'hE, APS_LO = 4'hF;
  // payload type codes
  localparam logic [7:0] PT_GFP = 8'h05, PT_NULL = 8'hFD, PT_PRBS = 8'hFE;
  localparam logic [7:0] PT_PROP = 8'h80, PT_NA = 8'hFF;
  // gfp header constants
  localparam logic [2:0] PTI_DATA = 3'h0;
  localparam logic [2:0] PTI_CMF  = 3'h4;
  localparam logic [7:0] UPI_LOS  = 8'h01;
  localparam logic [7:0] UPI_ETH  = 8'h01;
  localparam logic [9:0] ERR_10B  = 10'h0_1FE;
  // timing of the client fail frame
  localparam int unsigned CLK_HZ     = 125_000_000;
  localparam int unsigned CSF_INT_MS = 500;
  localparam int unsigned CSF_CYCLES = CLK_HZ / 1000 * CSF_INT_MS;
  // reset values
  localparam logic [31:0] RST_PM   = 32'h0000_0000;
  localparam logic [31:0] RST_APS  = 32'h0000_0000;
  localparam logic [31:0] RST_PSI  = 32'h0000_0000;
  localparam logic [31:0] RST_TRIB = 32'h0000_0000;
  localparam logic [31:0] RST_GFP  = 32'h0000_0001;
  localparam logic [31:0] RST_SYNC = 32'h0000_0001;
  // source of each tributary slot
  typedef enum logic [1:0] {SRC_MEAS, SRC_COPY, SRC_PRBS} odg_src_e;
  // frame-mapped header fields
  typedef struct packed {
    logic [2:0] pti;
    logic       pfi;
    logic [3:0] exi;
    logic [7:0] upi;
  } odg_hdr_s;
  // path monitor config: bdi force, raw enable, raw code, mode
  typedef struct packed {
    logic       bdi_force;
    logic       raw_en;
    logic [2:0] raw;
    logic [1:0] mode;
  } odg_pm_s;
  // protection config: raw enable, auto sf, type, request
  typedef struct packed {
    logic       raw_en;
    logic       auto_sf;
    logic [3:0] prot;
    logic [3:0] req;
  } odg_aps_s;
  // payload type config: raw enable, selection, raw code
  typedef struct packed {
    logic       raw_en;
    logic [2:0] sel;
    logic [7:0] raw;
  } odg_psi_s;
  // gfp config: csf frame mode, transparent mode, header
  typedef struct packed {
    logic     csf_mode;
    logic     transp;
    odg_hdr_s hdr;
  } odg_gfp_s;
endpackage

// >>> dv/odg_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checker for the overhead and gfp generator
module odg_core_chk #(
  parameter int unsigned CSF_CYCLES = 20,
  parameter int unsigned SLOT_W     = 7
) (
  input wire logic              SYS_CLK_I,
  input wire logic              RSTN_I,
  input wire logic [7:0]        AVS_ADDRESS_I,
  input wire logic              AVS_READ_I,
  input wire logic              AVS_WRITE_I,
  input wire logic [31:0]       AVS_READDATA_O,
  input wire logic              AVS_WAITREQUEST_O,
  input wire logic              SIG_FAIL_I,
  input wire logic [7:0]        PM_BYTE3_O,
  input wire logic              REPL_10B_O,
  input wire logic [9:0]        REPL_CODE_O,
  input wire logic              GFP_IDLE_O,
  input wire logic              GFP_CMF_O,
  input wire logic              CMF_REQ_O,
  input wire odg_pkg::odg_hdr_s GFP_HDR_O,
  input wire logic              RX_HDR_VALID_I,
  input wire logic              RX_HDR_OK_I,
  input wire logic              RX_SYNC_O
);
  logic [31:0] gap; // cycles since the last management frame request
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // spacing of management requests, restarted whenever idle frames stop
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I || !GFP_IDLE_O) gap <= 32'h0000_0000;
    else if (CMF_REQ_O) gap <= 32'h0000_0001;
    else if (gap != 32'h0000_0000) gap <= gap + 32'h0000_0001;
  end
  a_wait_one: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
    |=> !AVS_WAITREQUEST_O) else $error("wait state not exactly one cycle");
  a_unmapped_zero: assert property (AVS_READ_I && !AVS_WAITREQUEST_O
    && AVS_ADDRESS_I > odg_pkg::OFF_STAT |-> AVS_READDATA_O == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_bdi_follows: assert property (SIG_FAIL_I [*4] |-> PM_BYTE3_O[3])
    else $error("defect flag missing under signal fail");
  a_repl_code: assert property (REPL_10B_O |-> REPL_CODE_O == odg_pkg::ERR_10B)
    else $error("wrong replacement code");
  a_repl_excl: assert property (REPL_10B_O |-> !GFP_IDLE_O)
    else $error("block and frame replacement together");
  a_cmf_idle: assert property (CMF_REQ_O |-> GFP_IDLE_O)
    else $error("management request outside idle fill");
  a_cmf_gap: assert property (CMF_REQ_O && gap != 32'h0000_0000 |-> gap == CSF_CYCLES)
    else $error("management request spacing wrong");
  a_pti_mgmt: assert property (GFP_HDR_O.pti == odg_pkg::PTI_CMF |-> GFP_CMF_O)
    else $error("management type without management frames");
  a_sync_drop: assert property (RX_HDR_VALID_I && !RX_HDR_OK_I |=> !RX_SYNC_O)
    else $error("sync kept after bad header");
  a_sync_rise: assert property ($rose(RX_SYNC_O) |-> $past(RX_HDR_VALID_I && RX_HDR_OK_I))
    else $error("sync entered without good header");
endmodule
bind odg_core odg_core_chk #(.CSF_CYCLES(CSF_CYCLES), .SLOT_W(SLOT_W)) odg_core_chk_inst (
  .SYS_CLK_I, .RSTN_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_READDATA_O,
  .AVS_WAITREQUEST_O, .SIG_FAIL_I, .PM_BYTE3_O, .REPL_10B_O, .REPL_CODE_O, .GFP_IDLE_O,
  .GFP_CMF_O, .CMF_REQ_O, .GFP_HDR_O, .RX_HDR_VALID_I, .RX_HDR_OK_I, .RX_SYNC_O);
`default_nettype wire

// >>> dv/odg_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// receiving equipment: returns core header results, promptly or with gaps
module odg_far_end (
  input  wire logic clk_i,
  output logic      hdr_valid_o,
  output logic      hdr_ok_o
);
  logic ok_q = 1'b0; // result of the header on offer
  logic junk = 1'b0; // meaningless level while no header is offered
  initial hdr_valid_o = 1'b0;
  // the result line wanders between headers so a stale value is never trusted
  always @(posedge clk_i) junk <= ~junk;
  assign hdr_ok_o = hdr_valid_o ? ok_q : junk;
  // offer n headers with the same result, gap idle cycles after each
  task automatic send(input int n, input logic ok, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      hdr_valid_o <= 1'b1;
      ok_q <= ok;
      repeat (gap) begin
        @(posedge clk_i);
        hdr_valid_o <= 1'b0;
      end
    end
    @(posedge clk_i);
    hdr_valid_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/test_odu_overhead_gfp_tx.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the overhead and gfp generator
module test_odu_overhead_gfp_tx;
  localparam int unsigned CSF_N = 20;   // short management frame interval
  localparam int          LIMIT = 6000; // cycle ceiling for the run
  logic              clk = 1'b0;
  logic              rstn, rd, wr, sfail, cfail, waitreq, hv, hok;
  logic              repl, idle, cmf, cmf_req, sync;
  logic [7:0]        addr, pm, psi;
  logic [31:0]       wdata, rdo, rdata, aps;
  logic [6:0]        slot;
  logic [3:0]        be;
  logic [9:0]        rcode;
  odg_pkg::odg_src_e src;
  odg_pkg::odg_hdr_s hdr;
  int                error_cnt = 0, total_checks = 0, cyc = 0;
  odg_core #(.CSF_CYCLES(CSF_N), .SLOT_W(7)) odg_core_inst (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdo), .AVS_WAITREQUEST_O(waitreq), .SIG_FAIL_I(sfail),
    .CLIENT_FAIL_I(cfail), .SLOT_I(slot), .SLOT_SRC_O(src), .PM_BYTE3_O(pm),
    .APS_O(aps), .PSI0_O(psi), .REPL_10B_O(repl), .REPL_CODE_O(rcode),
    .GFP_IDLE_O(idle), .GFP_CMF_O(cmf), .CMF_REQ_O(cmf_req), .GFP_HDR_O(hdr),
    .RX_HDR_VALID_I(hv), .RX_HDR_OK_I(hok), .RX_SYNC_O(sync));
  odg_far_end odg_far_end_inst (.clk_i(clk), .hdr_valid_o(hv), .hdr_ok_o(hok));
  always #4 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one bus access, held until wait state clears
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (waitreq !== 1'b0);
    rdata = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    settle(2);
  endtask
  task automatic t_regs;
    bus(1'b0, odg_pkg::OFF_GFP, 32'h0);
    chk("gfp reset", rdata, odg_pkg::RST_GFP);
    bus(1'b0, odg_pkg::OFF_SYNC, 32'h0);
    chk("sync reset", rdata, odg_pkg::RST_SYNC);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", rdata, 32'h0);
    bus(1'b1, odg_pkg::OFF_STAT, 32'hFFFF_FFFF);
    bus(1'b0, odg_pkg::OFF_STAT, 32'h0);
    chk("status ro", rdata, 32'h0);
    bus(1'b1, odg_pkg::OFF_PM, 32'h0000_0041);
    bus(1'b0, odg_pkg::OFF_PM, 32'h0);
    chk("pm readback", rdata, 32'h0000_0041);
    // a write with every lane off must leave the register untouched
    be <= 4'h0;
    bus(1'b1, odg_pkg::OFF_PM, 32'h0000_0000);
    be <= 4'hF;
    bus(1'b0, odg_pkg::OFF_PM, 32'h0);
    chk("lanes off", rdata, 32'h0000_0041);
  endtask
  task automatic t_pm;
    logic [2:0] st [4] = '{odg_pkg::STAT_NORMAL, odg_pkg::STAT_LCK,
                           odg_pkg::STAT_OCI, odg_pkg::STAT_AIS};
    for (int m = 0; m < 4; m++) begin
      wreg(odg_pkg::OFF_PM, m);
      chk("stat", pm, {5'h00, st[m]});
    end
    sfail <= 1'b1;
    settle(4);
    chk("bdi on", pm, 8'h0F);
    sfail <= 1'b0;
    settle(4);
    chk("bdi off", pm, 8'h07);
    wreg(odg_pkg::OFF_PM, 32'h0000_002C);
    chk("raw stat", pm, 8'h03);
    wreg(odg_pkg::OFF_PM, 32'h0000_0040);
    chk("bdi force", pm, 8'h09);
  endtask
  task automatic t_aps;
    logic [3:0] code [10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE, 4'hF};
    foreach (code[i]) begin
      wreg(odg_pkg::OFF_APS, {24'h00_0000, 4'h9, code[i]});
      chk("aps req", aps[31:24], {code[i], 4'h9});
    end
    wreg(odg_pkg::OFF_APS, 32'h0000_0093);
    chk("aps resv", aps[31:24], {odg_pkg::APS_NR, 4'h9});
    wreg(odg_pkg::OFF_APS, 32'h0000_0293);
    chk("aps raw", aps[31:24], 8'h39);
    wreg(odg_pkg::OFF_APS, 32'h0000_0190);
    sfail <= 1'b1;
    settle(4);
    chk("aps sf", aps[31:24], {odg_pkg::APS_SF, 4'h9});
    sfail <= 1'b0;
    wreg(odg_pkg::OFF_APSX, 32'h0012_3456);
    settle(2);
    chk("aps nr", aps[31:24], {odg_pkg::APS_NR, 4'h9});
    chk("aps bytes", aps[23:0], 24'h12_3456);
  endtask
  task automatic t_psi;
    logic [7:0] pt [5] = '{odg_pkg::PT_GFP, odg_pkg::PT_NULL, odg_pkg::PT_PRBS,
                           odg_pkg::PT_PROP, odg_pkg::PT_NA};
    for (int i = 0; i < 5; i++) begin
      wreg(odg_pkg::OFF_PSI, i << 8);
      chk("psi sel", psi, pt[i]);
    end
    wreg(odg_pkg::OFF_PSI, 32'h0000_0855);
    chk("psi raw", psi, 8'h55);
  endtask
  task automatic t_trib;
    wreg(odg_pkg::OFF_TRIB, 32'h0000_0085);
    slot <= 7'h05;
    settle(2);
    chk("meas", src, odg_pkg::SRC_MEAS);
    slot <= 7'h06;
    settle(2);
    chk("copy", src, odg_pkg::SRC_COPY);
    wreg(odg_pkg::OFF_TRIB, 32'h0000_0005);
    chk("prbs", src, odg_pkg::SRC_PRBS);
  endtask
  task automatic t_gfp;
    int n;
    wreg(odg_pkg::OFF_GFP, 32'h0000_1A42);
    chk("hdr", hdr, 16'h1A42);
    chk("data frames", cmf, 1'b0);
    wreg(odg_pkg::OFF_GFP, 32'h0000_8001);
    chk("mgmt frames", cmf, 1'b1);
    chk("mgmt hdr", hdr, 16'h8001);
    wreg(odg_pkg::OFF_GFP, 32'h0001_0001);
    cfail <= 1'b1;
    settle(4);
    chk("10b repl", repl, 1'b1);
    chk("10b code", rcode, odg_pkg::ERR_10B);
    wreg(odg_pkg::OFF_GFP, 32'h0003_0001);
    chk("idle", idle, 1'b1);
    chk("csf frames", cmf, 1'b1);
    chk("csf hdr", hdr, {odg_pkg::PTI_CMF, 5'h00, odg_pkg::UPI_LOS});
    n = 0;
    while (cmf_req !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cmf_req !== 1'b1 && n < 100);
    chk("cmf spacing", n, CSF_N);
    cfail <= 1'b0;
    settle(4);
    chk("idle off", idle, 1'b0);
  endtask
  task automatic t_sync;
    wreg(odg_pkg::OFF_SYNC, 32'h0000_0003);
    odg_far_end_inst.send(2, 1'b1, 0);
    @(posedge clk);
    chk("hunt", sync, 1'b0);
    odg_far_end_inst.send(1, 1'b0, 0);
    odg_far_end_inst.send(3, 1'b1, 2);
    @(posedge clk);
    chk("sync", sync, 1'b1);
    odg_far_end_inst.send(1, 1'b0, 0);
    @(posedge clk);
    chk("lost", sync, 1'b0);
  endtask
  initial begin
    rstn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    sfail = 1'b0;
    cfail = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    slot = 7'h00;
    be = 4'hF;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    chk("pm reset", pm, 8'h01);
    t_regs;
    t_pm;
    t_aps;
    t_psi;
    t_trib;
    t_gfp;
    t_sync;
    print_verdict;
  end
endmodule
`default_nettype wire
